/* hw/acc_pkg.sv */
// Package: register map, field layout and types for the converter and comparator control
`default_nettype none
package acc_pkg;
  // Register byte addresses, one aligned 32-bit word each
  localparam logic [4:0] ACC_OFS_CMP_CTL = 5'h00;
  localparam logic [4:0] ACC_OFS_SPECIAL = 5'h04;
  localparam logic [4:0] ACC_OFS_CONV_CTL = 5'h08;
  localparam logic [4:0] ACC_OFS_MUX_SEL = 5'h0C;
  localparam logic [4:0] ACC_OFS_RES_LOW = 5'h10;
  localparam logic [4:0] ACC_OFS_RES_HIGH = 5'h14;

  // comparator_control_status fields
  localparam int ACC_CMP_DISABLE = 7;
  localparam int ACC_CMP_BANDGAP = 6;
  localparam int ACC_CMP_OUTPUT = 5;
  localparam int ACC_CMP_FLAG = 4;
  localparam int ACC_CMP_IRQ_EN = 3;
  localparam int ACC_CMP_ROUTE = 2;
  localparam int ACC_CMP_MODE_HI = 1;
  localparam int ACC_CMP_MODE_LO = 0;
  // special_function_reg fields
  localparam int ACC_SPC_MUX_EN = 3;
  // conv_control_status fields
  localparam int ACC_CNV_ENABLE = 7;
  localparam int ACC_CNV_START = 6;
  localparam int ACC_CNV_FREE = 5;
  localparam int ACC_CNV_FLAG = 4;
  localparam int ACC_CNV_IRQ_EN = 3;
  localparam int ACC_CNV_PS_HI = 2;
  localparam int ACC_CNV_PS_LO = 0;
  // conv_mux_select_reg fields
  localparam int ACC_MUX_REF_HI = 7;
  localparam int ACC_MUX_REF_LO = 6;
  localparam int ACC_MUX_LEFT = 5;
  localparam int ACC_MUX_CH_HI = 3;
  localparam int ACC_MUX_CH_LO = 0;

  localparam logic [7:0] ACC_RST_BYTE = 8'h00;
  localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_MODE_FALL = 2'h2;
  localparam logic [1:0] ACC_MODE_RISE = 2'h3;

  // Conversion timing in converter clock cycles
  localparam logic [4:0] ACC_NORMAL_CYCLES = 5'd13;
  localparam logic [4:0] ACC_FIRST_CYCLES = 5'd25;
  localparam logic [4:0] ACC_NORMAL_SAMPLE = 5'd1;
  localparam logic [4:0] ACC_FIRST_SAMPLE = 5'd13;
  localparam int ACC_RES_BITS = 10;
  localparam logic [9:0] ACC_SAR_MSB = 10'h200;

  typedef enum logic [0:0] {ACC_IDLE, ACC_CONVERT} acc_state_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acc_avs_req_type;

  typedef struct packed {
    logic enable;
    logic sample;
    logic [3:0] channel;
    logic [1:0] reference;
    logic [9:0] trial;
  } acc_sar_type;

  typedef struct packed {
    logic power_off;
    logic pos_bandgap;
    logic neg_from_mux;
    logic [2:0] neg_channel;
  } acc_cmp_sel_type;
endpackage
`default_nettype wire

/* hw/acc_adc_cmp_ctrl.sv */
// Digital control for the successive-approximation converter and analog comparator
// Operation
// [R1] Comparator flag sets on the event chosen by the interrupt mode field.
// [R2] Comparator request only while its enable and global enable are both one.
// [R3] Comparator flag clears on vector taken or on writing one to it.
// [R4] Route bit one feeds comparator output to timer capture; zero disconnects.
// [R5] Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// [R6] Software clears comparator enable before changing the mode field.
// [R7] Negative input from mux channel only if mux enabled and converter off.
// [R8] Each conversion yields a 10-bit successive approximation result.
// [R9] Channel may select any input pin, ground or the bandgap reference.
// [R10] Reference and channel selections take effect only while converter enabled.
// [R11] Result right aligned by default, left aligned when left-adjust is one.
// [R12] Reading low byte locks both result bytes until high byte is read.
// [R13] Software reads low byte first, unless left aligned 8-bit high read.
// [R14] Conversion complete flag still sets when a locked result is discarded.
// [R15] Start bit begins conversion, reads one throughout, clears at completion.
// [R16] Channel change during a conversion waits until that conversion completes.
// [R17] Free running converts continuously regardless of the complete flag.
// [R18] Prescaler set by select field, runs while enabled, held reset otherwise.
// [R19] Requested conversion begins at next prescaled converter clock edge.
// [R20] Software picks converter clock 50 to 200 kHz for full resolution.
// [R21] Normal conversion lasts 13 converter cycles, first after enable 25.
// [R22] Completion writes result, sets flag, clears start in single mode.
// [R23] Free running restarts immediately after completion while start stays set.
// [R24] Comparator output synchronised before status bit and event logic.
// [R25] Converter request while its flag and enable set; vector clears flag.
// [R26] Prescaler select maps to power-of-two divisions of the clock.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module acc_adc_cmp_ctrl
  import acc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire acc_avs_req_type i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_global_irq_enable,
  input wire logic i_cmp_vector_taken,
  input wire logic i_conv_vector_taken,
  output logic o_cmp_irq_req,
  output logic o_conv_irq_req,
  input wire logic i_cmp_raw,
  output acc_cmp_sel_type o_cmp_sel,
  output logic o_capture_in,
  input wire logic i_sar_cmp,
  output acc_sar_type o_sar
);

  // Register state
  logic [7:0] cmp_ctl;
  logic mux_en;
  logic conv_en;
  logic start;
  logic free_run;
  logic conv_flag;
  logic conv_irq_en;
  logic [2:0] ps_sel;
  logic [7:0] mux_sel;
  logic [9:0] result;
  logic locked;
  logic resp;

  // Comparator synchroniser and edge history
  logic cmp_sync1;
  logic cmp_sync2;
  logic cmp_prev;

  // Converter sequencing
  acc_state_type state;
  logic [6:0] ps_cnt;
  logic first_conv;
  logic [4:0] cyc;
  logic [4:0] total;
  logic [4:0] sample_at;
  logic [9:0] trial;
  logic [9:0] mask;
  logic [3:0] eff_ch;
  logic [1:0] eff_ref;
  logic [7:0] rdata;

  // Bus decode: every access takes one wait cycle
  wire req = i_avs.read | i_avs.write;
  wire done_acc = req & resp;
  wire wr = i_avs.write & done_acc & i_avs.byteenable[0];
  wire rd = i_avs.read & done_acc;
  wire [7:0] wd = i_avs.writedata[7:0];
  wire sel_cmp = i_avs.address == ACC_OFS_CMP_CTL;
  wire sel_spc = i_avs.address == ACC_OFS_SPECIAL;
  wire sel_cnv = i_avs.address == ACC_OFS_CONV_CTL;
  wire sel_mux = i_avs.address == ACC_OFS_MUX_SEL;
  wire sel_low = i_avs.address == ACC_OFS_RES_LOW;
  wire sel_high = i_avs.address == ACC_OFS_RES_HIGH;
  wire wr_cmp = wr & sel_cmp;
  wire wr_cnv = wr & sel_cnv;

  // Result alignment
  wire left = mux_sel[ACC_MUX_LEFT];
  wire [7:0] res_low = left ? {result[1:0], 6'h00} : result[7:0]; // R11
  wire [7:0] res_high = left ? result[9:2] : {6'h00, result[9:8]}; // R11

  // Comparator event selection
  wire [1:0] cmp_mode = cmp_ctl[ACC_CMP_MODE_HI:ACC_CMP_MODE_LO];
  wire cmp_rise = cmp_sync2 & ~cmp_prev;
  wire cmp_fall = ~cmp_sync2 & cmp_prev;
  wire cmp_event = (cmp_mode == ACC_MODE_TOGGLE) ? (cmp_rise | cmp_fall) : // R5
                   (cmp_mode == ACC_MODE_FALL) ? cmp_fall : // R5
                   (cmp_mode == ACC_MODE_RISE) ? cmp_rise : 1'b0; // R5
  wire cmp_flag_clr = i_cmp_vector_taken | (wr_cmp & wd[ACC_CMP_FLAG]); // R3
  wire next_cmp_flag = cmp_event | (cmp_ctl[ACC_CMP_FLAG] & ~cmp_flag_clr); // R1

  // Prescaler: select 0 and 1 both divide by two
  wire [2:0] ps_shift = (ps_sel == 3'h0) ? 3'h1 : ps_sel; // R26
  wire [7:0] ps_div = 8'h01 << ps_shift; // R26
  wire [6:0] ps_last = 7'(ps_div - 8'h01);
  wire tick = conv_en & (ps_cnt == ps_last); // R18

  // Conversion progress
  wire busy = state == ACC_CONVERT;
  wire last_cyc = busy & (cyc == 5'(total - 5'd1));
  wire complete = tick & last_cyc;
  wire sar_step = tick & busy & (cyc > sample_at) & (mask != 10'h000);
  wire [9:0] next_trial = (i_sar_cmp ? trial : (trial & ~mask)) | (mask >> 1); // R8
  wire begin_conv = tick & ~busy & start; // R19
  wire restart = complete & free_run & start; // R23
  wire start_set = wr_cnv & wd[ACC_CNV_START] & wd[ACC_CNV_ENABLE]; // R15
  wire conv_flag_clr = i_conv_vector_taken | (wr_cnv & wd[ACC_CNV_FLAG]); // R25

  // Read multiplexer, unmapped offsets read zero
  always_comb
  begin
    rdata = 8'h00;
    if (sel_cmp)
    begin
      rdata = cmp_ctl;
      rdata[ACC_CMP_OUTPUT] = cmp_sync2; // R24
    end
    else if (sel_spc)
      rdata[ACC_SPC_MUX_EN] = mux_en;
    else if (sel_cnv)
      rdata = {conv_en, start, free_run, conv_flag, conv_irq_en, ps_sel}; // R15
    else if (sel_mux)
      rdata = mux_sel;
    else if (sel_low)
      rdata = res_low;
    else if (sel_high)
      rdata = res_high;
  end

  // Bus response
  assign o_avs_waitrequest = req & ~resp;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      resp <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      resp <= req & ~resp;
      if (req & ~resp)
        o_avs_readdata <= {24'h00_0000, rdata};
    end
  end

  // Comparator path
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmp_sync1 <= 1'b0;
      cmp_sync2 <= 1'b0;
      cmp_prev <= 1'b0;
    end
    else
    begin
      cmp_sync1 <= i_cmp_raw; // R24
      cmp_sync2 <= cmp_sync1; // R24
      cmp_prev <= cmp_sync2;
    end
  end

  // Mode changes raise no event by themselves; software masks the enable first
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cmp_ctl <= ACC_RST_BYTE;
    else
    begin
      if (wr_cmp)
      begin
        cmp_ctl[ACC_CMP_DISABLE] <= wd[ACC_CMP_DISABLE];
        cmp_ctl[ACC_CMP_BANDGAP] <= wd[ACC_CMP_BANDGAP];
        cmp_ctl[ACC_CMP_IRQ_EN] <= wd[ACC_CMP_IRQ_EN]; // R2
        cmp_ctl[ACC_CMP_ROUTE] <= wd[ACC_CMP_ROUTE];
        cmp_ctl[ACC_CMP_MODE_HI:ACC_CMP_MODE_LO] <= wd[ACC_CMP_MODE_HI:ACC_CMP_MODE_LO]; // R6
      end
      cmp_ctl[ACC_CMP_FLAG] <= next_cmp_flag; // R1
    end
  end

  assign o_cmp_irq_req = cmp_ctl[ACC_CMP_FLAG] & cmp_ctl[ACC_CMP_IRQ_EN]
                         & i_global_irq_enable; // R2
  assign o_capture_in = cmp_ctl[ACC_CMP_ROUTE] & cmp_sync2; // R4
  assign o_cmp_sel.power_off = cmp_ctl[ACC_CMP_DISABLE];
  assign o_cmp_sel.pos_bandgap = cmp_ctl[ACC_CMP_BANDGAP];
  assign o_cmp_sel.neg_from_mux = mux_en & ~conv_en; // R7
  assign o_cmp_sel.neg_channel = mux_sel[2:0]; // R7

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mux_en <= 1'b0;
      conv_en <= 1'b0;
      free_run <= 1'b0;
      conv_irq_en <= 1'b0;
      ps_sel <= 3'h0;
      mux_sel <= ACC_RST_BYTE;
    end
    else
    begin
      if (wr & sel_spc)
        mux_en <= wd[ACC_SPC_MUX_EN];
      if (wr_cnv)
      begin
        conv_en <= wd[ACC_CNV_ENABLE];
        free_run <= wd[ACC_CNV_FREE];
        conv_irq_en <= wd[ACC_CNV_IRQ_EN];
        ps_sel <= wd[ACC_CNV_PS_HI:ACC_CNV_PS_LO]; // R18
      end
      if (wr & sel_mux)
        mux_sel <= wd;
    end
  end

  // Start bit and complete flag: a set wins over any clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      start <= 1'b0;
      conv_flag <= 1'b0;
    end
    else
    begin
      if (start_set)
        start <= 1'b1; // R15
      else if (wr_cnv & ~wd[ACC_CNV_ENABLE])
        start <= 1'b0;
      else if (complete & ~free_run)
        start <= 1'b0; // R22
      conv_flag <= complete | (conv_flag & ~conv_flag_clr); // R14
    end
  end

  assign o_conv_irq_req = conv_flag & conv_irq_en & i_global_irq_enable; // R25

  // Prescaler counts only while enabled
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ps_cnt <= 7'h00;
    else if (!conv_en || tick)
      ps_cnt <= 7'h00; // R18
    else
      ps_cnt <= ps_cnt + 7'h01; // R18
  end

  // Effective selections track the register only when safe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      eff_ch <= 4'h0;
      eff_ref <= 2'h0;
    end
    else if (conv_en && (!busy || last_cyc) && !begin_conv)
    begin
      eff_ch <= mux_sel[ACC_MUX_CH_HI:ACC_MUX_CH_LO]; // R16
      eff_ref <= mux_sel[ACC_MUX_REF_HI:ACC_MUX_REF_LO]; // R10
    end
  end

  // Result lock between low and high byte reads
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      locked <= 1'b0;
      result <= 10'h000;
    end
    else
    begin
      if (rd & sel_high)
        locked <= 1'b0; // R12
      else if (rd & sel_low)
        locked <= 1'b1; // R12
      if (complete && !locked)
        result <= trial; // R22
    end
  end

  // Conversion sequencer on prescaled clock ticks
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= ACC_IDLE;
      first_conv <= 1'b1;
      cyc <= 5'd0;
      total <= ACC_NORMAL_CYCLES;
      sample_at <= ACC_NORMAL_SAMPLE;
      trial <= 10'h000;
      mask <= 10'h000;
    end
    else if (!conv_en)
    begin
      // Disabling aborts and rearms the long first conversion
      state <= ACC_IDLE;
      first_conv <= 1'b1;
      cyc <= 5'd0;
    end
    else
    begin
      case (state)
        ACC_IDLE:
        begin
          if (begin_conv)
          begin
            state <= ACC_CONVERT; // R19
            cyc <= 5'd0;
            first_conv <= 1'b0;
            total <= first_conv ? ACC_FIRST_CYCLES : ACC_NORMAL_CYCLES; // R21
            sample_at <= first_conv ? ACC_FIRST_SAMPLE : ACC_NORMAL_SAMPLE; // R21
          end
        end
        ACC_CONVERT:
        begin
          if (tick)
          begin
            if (cyc == sample_at)
            begin
              trial <= ACC_SAR_MSB; // R8
              mask <= ACC_SAR_MSB;
            end
            else if (sar_step)
            begin
              trial <= next_trial; // R8
              mask <= mask >> 1;
            end
            if (last_cyc)
            begin
              cyc <= 5'd0;
              total <= ACC_NORMAL_CYCLES;
              sample_at <= ACC_NORMAL_SAMPLE;
              if (!restart)
                state <= ACC_IDLE; // R22
              else
                state <= ACC_CONVERT; // R17 R23
            end
            else
              cyc <= cyc + 5'd1;
          end
        end
        default:
          state <= ACC_IDLE;
      endcase
    end
  end

  assign o_sar.enable = conv_en;
  // Gated by enable so an abort stops sampling at once
  assign o_sar.sample = conv_en & busy & (cyc <= sample_at); // R8
  assign o_sar.channel = eff_ch; // R9
  assign o_sar.reference = eff_ref; // R10
  assign o_sar.trial = trial;

endmodule
`default_nettype wire

/* testbench/acc_ctrl_props.sv */
// Checker of port relations for the converter and comparator control
`timescale 1ns/10ps
`default_nettype none
module acc_ctrl_props
  import acc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire acc_avs_req_type i_avs,
  input wire logic i_global_irq_enable,
  input wire logic i_cmp_vector_taken,
  input wire logic i_conv_vector_taken,
  input wire logic o_cmp_irq_req,
  input wire logic o_conv_irq_req,
  input wire logic i_cmp_raw,
  input wire acc_cmp_sel_type o_cmp_sel,
  input wire logic o_capture_in,
  input wire acc_sar_type o_sar
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_cmp_gate: assert property (o_cmp_irq_req |-> i_global_irq_enable)
    else $error("comparator request without global enable");
  chk_cmp_vector: assert property (i_cmp_vector_taken |=> !o_cmp_irq_req)
    else $error("comparator flag kept after vector");
  chk_conv_vector: assert property (i_conv_vector_taken |=> !o_conv_irq_req)
    else $error("conversion flag kept after vector");
  // Writes excluded: enabling with a pending flag also raises the request
  chk_cmp_event: assert property (
    $rose(o_cmp_irq_req) && $stable(i_global_irq_enable) && !$past(i_avs.write)
    |-> $past(i_cmp_raw, 3) != $past(i_cmp_raw, 4))
    else $error("comparator flag without a matching edge");
  chk_capture_sync: assert property ($rose(o_capture_in) |-> $past(i_cmp_raw, 2))
    else $error("capture input not from synchronised output");
  chk_neg_mux: assert property (o_cmp_sel.neg_from_mux |-> !o_sar.enable)
    else $error("negative input from mux while converter on");
  chk_sel_frozen: assert property (
    !o_sar.enable && !$past(o_sar.enable)
    |-> $stable(o_sar.channel) && $stable(o_sar.reference))
    else $error("selection changed while converter off");
  chk_chan_locked: assert property (
    o_sar.sample && $past(o_sar.sample) |-> $stable(o_sar.channel))
    else $error("channel changed during sampling");
  chk_off_idle: assert property (!o_sar.enable |-> !o_sar.sample)
    else $error("sampling while converter off");
endmodule
bind acc_adc_cmp_ctrl acc_ctrl_props i_acc_ctrl_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_avs(i_avs), .i_global_irq_enable(i_global_irq_enable),
  .i_cmp_vector_taken(i_cmp_vector_taken), .i_conv_vector_taken(i_conv_vector_taken),
  .o_cmp_irq_req(o_cmp_irq_req), .o_conv_irq_req(o_conv_irq_req), .i_cmp_raw(i_cmp_raw),
  .o_cmp_sel(o_cmp_sel), .o_capture_in(o_capture_in), .o_sar(o_sar));
`default_nettype wire

/* testbench/acc_analog_model.sv */
// Behavioural analog core answering the successive-approximation trials
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model
  import acc_pkg::*;
(
  input wire logic i_clk,
  input wire acc_sar_type i_sar,
  input wire logic [9:0] i_level,
  output logic o_keep
);
  logic last = 1'b0;
  // Powered-down core shows a changing level, never a held one
  assign o_keep = i_sar.enable ? (i_level >= i_sar.trial) : ~last;
  always_ff @(posedge i_clk)
  begin
    last <= o_keep;
  end
endmodule
`default_nettype wire

/* testbench/acc_adc_cmp_ctrl_test.sv */
// Self-checking bench for the converter and comparator control
`timescale 1ns/10ps
`default_nettype none
module acc_adc_cmp_ctrl_test
  import acc_pkg::*;
;
  logic clk, rst_n, gie, cvt, dvt, raw, keep, wreq, capt, cirq, dirq;
  acc_avs_req_type req;
  acc_cmp_sel_type sel;
  acc_sar_type sar;
  logic [31:0] rdata, q;
  logic [9:0] lvl;
  int err_total, checks_done;

  acc_adc_cmp_ctrl i_acc_adc_cmp_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_avs(req),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_global_irq_enable(gie),
    .i_cmp_vector_taken(cvt), .i_conv_vector_taken(dvt), .o_cmp_irq_req(cirq),
    .o_conv_irq_req(dirq), .i_cmp_raw(raw), .o_cmp_sel(sel), .o_capture_in(capt),
    .i_sar_cmp(keep), .o_sar(sar));
  acc_analog_model i_acc_analog_model (.i_clk(clk), .i_sar(sar), .i_level(lvl), .o_keep(keep));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang;
    err_total++;
    $display("mismatch at %0t: wait ran out", $time);
    tally_and_finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tk(input int m);
    repeat (m) @(posedge clk);
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    req <= '{read: !w, write: w, address: a, writedata: {24'h0, d}, byteenable: 4'hF};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wreq !== 1'b0 && k < 64);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (k >= 64)
      hang;
  endtask

  task automatic wait_done(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (dirq !== 1'b1 && c < 400);
    if (c >= 400)
      hang;
  endtask

  task automatic t_reset;
    // 0x18 lies outside the map and must read zero
    for (logic [5:0] a = 0; a < 6'h1C; a += 4)
    begin
      bus(1'b0, a[4:0], 8'h00);
      chk(q, 32'h0);
    end
    $display("test reset done");
  endtask

  task automatic t_cmp;
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      bus(1'b1, 5'h00, {6'h04, m});
      bus(1'b1, 5'h00, {6'h06, m});
      raw <= 1'b1;
      tk(6);
      chk(cirq, m == 2'h0 || m == 2'h3);
      bus(1'b1, 5'h00, {6'h06, m});
      tk(1);
      chk(cirq, 1'b0);
      raw <= 1'b0;
      tk(6);
      chk(cirq, m == 2'h0 || m == 2'h2);
      gie <= 1'b0;
      tk(1);
      chk(cirq, 1'b0);
      gie <= 1'b1;
      cvt <= 1'b1;
      tk(1);
      cvt <= 1'b0;
      tk(1);
      chk(cirq, 1'b0);
    end
    bus(1'b1, 5'h00, 8'h04);
    raw <= 1'b1;
    tk(4);
    chk(capt, 1'b1);
    bus(1'b0, 5'h00, 8'h00);
    chk(q[5], 1'b1);
    bus(1'b1, 5'h00, 8'hC0);
    tk(1);
    chk(capt, 1'b0);
    chk({sel.power_off, sel.pos_bandgap}, 2'h3);
    raw <= 1'b0;
    $display("test comparator done");
  endtask

  task automatic t_mux;
    bus(1'b1, 5'h04, 8'h08);
    bus(1'b1, 5'h0C, 8'h05);
    tk(1);
    chk(sel.neg_from_mux, 1'b1);
    chk(sel.neg_channel, 3'h5);
    chk(sar.channel, 4'h0);
    $display("test mux done");
  endtask

  task automatic t_conv;
    int c;
    lvl <= 10'h2A5;
    bus(1'b1, 5'h08, 8'hC8);
    bus(1'b0, 5'h08, 8'h00);
    chk(q[6], 1'b1);
    chk(sel.neg_from_mux, 1'b0);
    chk(sar.channel, 4'h5);
    wait_done(c);
    chk(c >= 40 && c <= 52, 1'b1);
    bus(1'b0, 5'h08, 8'h00);
    chk(q[7:4], 4'h9);
    bus(1'b0, 5'h10, 8'h00);
    chk(q, 32'hA5);
    bus(1'b0, 5'h14, 8'h00);
    chk(q, 32'h02);
    dvt <= 1'b1;
    tk(1);
    dvt <= 1'b0;
    tk(1);
    chk(dirq, 1'b0);
    // Low byte read first: the next result must be dropped
    lvl <= 10'h1C3;
    bus(1'b0, 5'h10, 8'h00);
    bus(1'b1, 5'h08, 8'hC8);
    tk(4);
    bus(1'b1, 5'h0C, 8'h06);
    tk(2);
    chk(sar.channel, 4'h5);
    wait_done(c);
    chk(c > 10 && c < 30, 1'b1);
    tk(1);
    chk(sar.channel, 4'h6);
    bus(1'b0, 5'h14, 8'h00);
    chk(q, 32'h02);
    bus(1'b1, 5'h08, 8'h98);
    lvl <= 10'h15A;
    bus(1'b1, 5'h0C, 8'hEF);
    tk(2);
    chk(sar.channel, 4'hF);
    chk(sar.reference, 2'h3);
    bus(1'b1, 5'h08, 8'hC8);
    wait_done(c);
    bus(1'b0, 5'h10, 8'h00);
    chk(q, 32'h80);
    bus(1'b0, 5'h14, 8'h00);
    chk(q, 32'h56);
    $display("test conversion done");
  endtask

  task automatic t_free;
    int r;
    int t[3];
    logic p;
    bus(1'b1, 5'h08, 8'h00);
    // Fast converter clock: ideal core, so resolution is not at stake
    bus(1'b1, 5'h08, 8'hE2);
    r = 0;
    p = 1'b0;
    for (int i = 0; i < 600 && r < 3; i++)
    begin
      @(posedge clk);
      if (sar.sample === 1'b1 && p === 1'b0)
      begin
        t[r] = i;
        r++;
      end
      p = sar.sample;
    end
    if (r < 3)
      hang;
    chk(t[2] - t[1], 52);
    bus(1'b0, 5'h08, 8'h00);
    chk(q[6], 1'b1);
    chk(q[4], 1'b1);
    bus(1'b1, 5'h08, 8'h00);
    tk(1);
    chk(sar.enable, 1'b0);
    bus(1'b0, 5'h08, 8'h00);
    chk(q[6], 1'b0);
    $display("test free running done");
  endtask

  initial
  begin
    err_total = 0;
    checks_done = 0;
    req = '0;
    gie = 1'b1;
    cvt = 1'b0;
    dvt = 1'b0;
    raw = 1'b0;
    lvl = 10'h000;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_cmp;
    t_mux;
    t_conv;
    t_free;
    tally_and_finish;
  end
endmodule
`default_nettype wire
